// *** logic/tbc_map.svh ***
`ifndef TBC_MAP_SVH
`define TBC_MAP_SVH
// Register word offsets on the Avalon-MM slave (address bits 5:2).
`define TBC_OFS_CONTROL    4'h0
`define TBC_OFS_COUNT_LOW  4'h1
`define TBC_OFS_COUNT_HIGH 4'h2
`define TBC_OFS_STATUS     4'h3
`define TBC_OFS_MASK       4'h4
`define TBC_OFS_OSC        4'h5
`define TBC_ADDR_W         6
// Control register field positions.
`define TBC_BIT_WIDE       7
`define TBC_BIT_SEL_HI     6
`define TBC_BIT_PS_HI      5
`define TBC_BIT_PS_LO      4
`define TBC_BIT_SEL_LO     3
`define TBC_BIT_SYNC_OFF   2
`define TBC_BIT_CLK_SRC    1
`define TBC_BIT_RUN        0
// Status and mask bit positions.
`define TBC_BIT_OVF        0
`define TBC_BIT_TRIG       1
// Reset values.
`define TBC_RST_CONTROL    8'h00
`define TBC_RST_COUNT      16'h0000
// Internal instruction clock divides the system clock by four.
`define TBC_INSN_DIV       2'h3
// Compare mode code that fires the special-event trigger.
`define TBC_CC_TRIG_MODE   4'hB
`endif

// *** logic/tbc_pkg.sv ***
package tbc_pkg;
   typedef enum logic [1:0] {TBC_INTERNAL, TBC_EXT_SYNC, TBC_EXT_ASYNC}
      tbc_mode_type;
   typedef enum logic {TBC_ARMED_WAIT, TBC_ARMED} tbc_arm_type;
endpackage

// *** logic/tbc_edge_detect.sv ***
`timescale 1ns/1ps
// Detects a rising edge of the external count source, optionally through a
// two-flop synchronizer, and only after a falling edge has been seen.
module tbc_edge_detect
   import tbc_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rst,
   // Control.
   input  wire logic enable,
   input  wire logic bypassSync,
   input  wire logic extIn,
   // Result.
   output logic      riseEvent
);
   import tbc_pkg::*;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        prevLvl;
      tbc_arm_type arm;
   } tbc_edge_state_type;

   tbc_edge_state_type s_q;
   tbc_edge_state_type s_d;
   logic               lvl;

   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = extIn;
      s_d.sync2 = s_q.sync1;
      lvl = bypassSync ? extIn : s_q.sync2;
      s_d.prevLvl = lvl;
      riseEvent = 1'b0;
      if (!enable)
      begin
         s_d.arm = TBC_ARMED_WAIT;
      end
      else
      begin
         unique case (s_q.arm)
            TBC_ARMED_WAIT:
               if (s_q.prevLvl && !lvl)
                  s_d.arm = TBC_ARMED;
            TBC_ARMED:
               riseEvent = !s_q.prevLvl && lvl;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         s_q <= '{1'b0, 1'b0, 1'b0, TBC_ARMED_WAIT};
      else
         s_q <= s_d;
   end
endmodule

// *** logic/tbc_prescaler.sv ***
`timescale 1ns/1ps
// Divides count ticks by 1, 2, 4 or 8.
module tbc_prescaler
   import tbc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Control.
   input  wire logic [1:0] prescaleSel,
   input  wire logic       clear,
   input  wire logic       tickIn,
   // Result.
   output logic            tickOut
);
   import tbc_pkg::*;

   typedef struct packed {
      logic [2:0] cnt;
   } tbc_ps_state_type;

   tbc_ps_state_type s_q;
   tbc_ps_state_type s_d;
   logic [2:0]       lastVal;

   always_comb
   begin
      s_d = s_q;
      unique case (prescaleSel)
         2'h0: lastVal = 3'h0;
         2'h1: lastVal = 3'h1;
         2'h2: lastVal = 3'h3;
         2'h3: lastVal = 3'h7;
      endcase
      tickOut = tickIn && (s_q.cnt >= lastVal);
      if (clear)
         s_d.cnt = 3'h0;
      else if (tickOut)
         s_d.cnt = 3'h0;
      else if (tickIn)
         s_d.cnt = 3'(s_q.cnt + 3'h1);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         s_q <= '{cnt: 3'h0};
      else
         s_q <= s_d;
   end
endmodule

// *** logic/tbc_timer.sv ***
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "tbc_map.svh"
// Notes on behaviour
// - Wide-access bit set makes the count a single 16-bit access.
// - Time-base select bits choose this or the other timer per unit.
// - Prescale field divides input ticks by 1, 2, 4 or 8.
// - External input is synchronized unless the sync-disable bit is set.
// - Internal source ignores the sync-disable bit and counts cycles.
// - External count takes rising edges only after a first falling edge.
// - Internal source increments once per system clock divided by four.
// - Run bit starts and stops the counter.
// - Three modes: internal timer, synced and unsynced external counter.
// - Enabled secondary oscillator forces its pins to inputs reading zero.
// - Wide mode: low-byte read copies live high byte into buffer.
// - Wide mode: high write fills buffer; low write loads both bytes.
// - Only a low-byte write clears the prescaler.
// - Count rolls FFFFh to 0000h and sets the overflow flag.
// - Compare trigger code 1011 from a unit on this timer resets count.
// - A software count write beats a coincident trigger reset.
// - Second unit trigger resets without setting the overflow flag.
module tbc_timer
   import tbc_pkg::*;
(
   // Clock and reset.
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // Avalon-MM slave.
   input  wire logic [`TBC_ADDR_W-1:0]  avsAddress,
   input  wire logic                    avsRead,
   input  wire logic                    avsWrite,
   input  wire logic [31:0]             avsWritedata,
   input  wire logic [3:0]              avsByteenable,
   output logic      [31:0]             avsReaddata,
   output logic                         avsWaitrequest,
   // External count sources.
   input  wire logic                    externalCountPin,
   input  wire logic                    secOscInPin,
   // Capture/compare units.
   input  wire logic [3:0]              ccMode1,
   input  wire logic [3:0]              ccMode2,
   input  wire logic                    ccMatch1,
   input  wire logic                    ccMatch2,
   output logic                         ccUnit1UsesThis,
   output logic                         ccUnit2UsesThis,
   // Port pins shared with the oscillator.
   input  wire logic [1:0]              portPinIn,
   output logic      [1:0]              portReadValue,
   output logic      [1:0]              portPinForceInput,
   // Interrupt.
   output logic                         irq
);
   import tbc_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] count;
      logic [7:0]  highBuf;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        oscEn;
      logic [1:0]  insnDiv;
      logic        ack;
      logic [31:0] rdata;
   } tbc_state_type;

   tbc_state_type s_q;
   tbc_state_type s_d;
   tbc_mode_type  mode;
   logic          running;
   logic          extRise;
   logic          rawTick;
   logic          tick;
   logic          psClear;
   logic          access;
   logic          wrLow;
   logic          wrHigh;
   logic          trig1;
   logic          trig2;
   logic [3:0]    wordIdx;
   logic [7:0]    wb;
   logic          commit;
   logic          wrAny;
   logic          rdCommit;
   logic          evOvf;
   logic          evTrig;
   logic [1:0]    evSet;
   logic [7:0]    rdByte;

   // Byte that a read of one register word returns; status shows the
   // events of this cycle as well, so none of them is lost by the clear.
   function automatic logic [7:0] read_byte(input logic [3:0]    idx,
                                            input tbc_state_type st,
                                            input logic [1:0]    ev);
      logic [7:0] r;
      r = 8'h00;
      unique case (idx)
         `TBC_OFS_CONTROL:
            r = st.ctrl;
         `TBC_OFS_COUNT_LOW:
            r = st.count[7:0];
         `TBC_OFS_COUNT_HIGH:
            r = st.ctrl[`TBC_BIT_WIDE] ? st.highBuf
                                       : st.count[15:8];
         `TBC_OFS_STATUS:
            r = {6'h00, st.status | ev};
         `TBC_OFS_MASK:
            r = {6'h00, st.mask};
         `TBC_OFS_OSC:
            r = {7'h00, st.oscEn};
         default:
            r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic cc_fires(input logic [3:0] md, input logic hit,
                                     input logic uses);
      return uses && hit && (md == `TBC_CC_TRIG_MODE);
   endfunction

   tbc_edge_detect uEdge (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .enable     (running && mode != TBC_INTERNAL),
      .bypassSync (s_q.ctrl[`TBC_BIT_SYNC_OFF]),
      .extIn      (s_q.oscEn ? secOscInPin : externalCountPin),
      .riseEvent  (extRise)
   );

   tbc_prescaler uPs (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .prescaleSel (s_q.ctrl[`TBC_BIT_PS_HI:`TBC_BIT_PS_LO]),
      .clear       (psClear),
      .tickIn      (rawTick),
      .tickOut     (tick)
   );

   always_comb
   begin
      // Mode decode; the sync bit only matters for the external source.
      if (!s_q.ctrl[`TBC_BIT_CLK_SRC])
         mode = TBC_INTERNAL;
      else if (s_q.ctrl[`TBC_BIT_SYNC_OFF])
         mode = TBC_EXT_ASYNC;
      else
         mode = TBC_EXT_SYNC;
      running = s_q.ctrl[`TBC_BIT_RUN];
      ccUnit1UsesThis = s_q.ctrl[`TBC_BIT_SEL_HI];
      ccUnit2UsesThis = s_q.ctrl[`TBC_BIT_SEL_HI]
                        | s_q.ctrl[`TBC_BIT_SEL_LO];
      if (mode == TBC_INTERNAL)
         rawTick = running && (s_q.insnDiv == `TBC_INSN_DIV);
      else
         rawTick = running && extRise;
      portPinForceInput = {2{s_q.oscEn}};
      portReadValue = s_q.oscEn ? 2'h0 : portPinIn;
      irq = |(s_q.status & s_q.mask);

      // The first cycle of a request prepares the read data and, on a wide
      // low-byte read, copies the high byte; the rest of the access lands at
      // the edge where waitrequest is low.
      access = (avsRead || avsWrite) && !s_q.ack;
      commit = (avsRead || avsWrite) && s_q.ack;
      avsWaitrequest = (avsRead || avsWrite) && !s_q.ack;
      avsReaddata = s_q.rdata;
      wordIdx = avsAddress[`TBC_ADDR_W-1:2];
      wb = avsByteenable[0] ? avsWritedata[7:0] : 8'h00;
      wrAny = commit && avsWrite && avsByteenable[0];
      rdCommit = commit && avsRead;
      wrLow = wrAny && wordIdx == `TBC_OFS_COUNT_LOW;
      wrHigh = wrAny && wordIdx == `TBC_OFS_COUNT_HIGH;
      psClear = wrLow;
      // Unsynchronized mode may miss the reset; it is applied anyway here.
      trig1 = cc_fires(ccMode1, ccMatch1, ccUnit1UsesThis);
      trig2 = cc_fires(ccMode2, ccMatch2, ccUnit2UsesThis);
      // A second-unit trigger swallows a coincident rollover flag.
      evOvf = tick && s_q.count == 16'hFFFF && !trig2;
      evTrig = trig1 || trig2;
      evSet = {evTrig, evOvf};
      rdByte = read_byte(wordIdx, s_q, evSet);

      s_d = s_q;
      s_d.ack = access;
      s_d.insnDiv = running ? 2'(s_q.insnDiv + 2'h1) : s_q.insnDiv;

      if (tick)
      begin
         s_d.count = 16'(s_q.count + 16'h0001);
      end
      if (evTrig)
      begin
         s_d.count = `TBC_RST_COUNT;
      end

      // A status read clears only the bits that it reported, and events of
      // the clearing cycle are set after the clear, so set wins.
      if (rdCommit && wordIdx == `TBC_OFS_STATUS)
      begin
         s_d.status = s_q.status & ~s_q.rdata[1:0];
      end
      s_d.status = s_d.status | evSet;

      // Register writes come after count updates so the write wins.
      if (wrAny)
      begin
         unique case (wordIdx)
            `TBC_OFS_CONTROL: s_d.ctrl = wb;
            `TBC_OFS_MASK:    s_d.mask = wb[1:0];
            `TBC_OFS_OSC:     s_d.oscEn = wb[0];
            default:          ;
         endcase
      end
      if (wrHigh)
      begin
         if (s_q.ctrl[`TBC_BIT_WIDE])
         begin
            s_d.highBuf = wb;
         end
         else
         begin
            s_d.count[15:8] = wb;
            if (evTrig)
               s_d.count[7:0] = s_q.count[7:0];
         end
      end
      if (wrLow)
      begin
         s_d.count[7:0] = wb;
         if (s_q.ctrl[`TBC_BIT_WIDE])
            s_d.count[15:8] = s_q.highBuf;
         else if (evTrig)
            s_d.count[15:8] = s_q.count[15:8];
      end

      // Read data are registered in the first cycle and stand at the edge
      // where the master takes them. The high byte is copied in the same
      // cycle as the low byte is captured, so the pair stays consistent.
      if (access && avsRead)
      begin
         s_d.rdata = {24'h000000, rdByte};
         if (wordIdx == `TBC_OFS_COUNT_LOW && s_q.ctrl[`TBC_BIT_WIDE])
            s_d.highBuf = s_q.count[15:8];
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         s_q <= '{ctrl:    `TBC_RST_CONTROL,
                  count:   `TBC_RST_COUNT,
                  highBuf: 8'h00,
                  status:  2'h0,
                  mask:    2'h0,
                  oscEn:   1'b0,
                  insnDiv: 2'h0,
                  ack:     1'b0,
                  rdata:   32'h00000000};
      else
         s_q <= s_d;
   end
endmodule

// *** tb/tbc_timer_props.sv ***
`timescale 1ns/1ps
`include "tbc_map.svh"
module tbc_timer_props
(
   // Clock and reset.
   input wire logic                   clk_sys,
   input wire logic                   rst,
   // Register bus.
   input wire logic [`TBC_ADDR_W-1:0] avsAddress,
   input wire logic                   avsRead,
   input wire logic                   avsWrite,
   input wire logic [31:0]            avsWritedata,
   input wire logic [3:0]             avsByteenable,
   input wire logic [31:0]            avsReaddata,
   input wire logic                   avsWaitrequest,
   // Time base and pins.
   input wire logic                   ccUnit1UsesThis,
   input wire logic                   ccUnit2UsesThis,
   input wire logic [1:0]             portPinIn,
   input wire logic [1:0]             portReadValue,
   input wire logic [1:0]             portPinForceInput,
   input wire logic                   irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic wrDone = avsWrite && !avsWaitrequest && avsByteenable[0];
   wire logic ctlWr = wrDone && avsAddress[5:2] == 4'h0;
   wire logic oscWr = wrDone && avsAddress[5:2] == 4'h5;
   wait_first_a: assert property ($rose(avsRead || avsWrite)
      |-> avsWaitrequest) else $error("no wait state on new request");
   wait_one_a: assert property ((avsRead || avsWrite) && avsWaitrequest
      |=> !avsWaitrequest) else $error("wait state too long");
   unmapped_zero_a: assert property (avsRead && !avsWaitrequest
      && avsAddress[5:2] > 4'h5 |-> avsReaddata == 32'h0)
      else $error("unmapped read not zero");
   unit_one_a: assert property (ctlWr
      |=> ccUnit1UsesThis == $past(avsWritedata[6]))
      else $error("unit one time base wrong");
   unit_two_a: assert property (ctlWr |=> ccUnit2UsesThis ==
      ($past(avsWritedata[6]) | $past(avsWritedata[3])))
      else $error("unit two time base wrong");
   osc_force_a: assert property (oscWr
      |=> portPinForceInput == {2{$past(avsWritedata[0])}})
      else $error("pin direction not forced");
   osc_zero_a: assert property (portPinForceInput == 2'b11
      |-> portReadValue == 2'b00) else $error("pin read not zero");
   osc_pass_a: assert property (portPinForceInput == 2'b00
      |-> portReadValue == portPinIn) else $error("pin read wrong");
   cover property (avsRead && !avsWaitrequest);
   cover property ($rose(irq));
   cover property (ccUnit2UsesThis && !ccUnit1UsesThis);
endmodule
bind tbc_timer tbc_timer_props u_props (.*);

// *** tb/tbc_pulse_src.sv ***
`timescale 1ns/1ps
// Square wave count source while enabled, resting low otherwise.
module tbc_pulse_src
#(
   parameter int HALF = 2
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Control and wave.
   input wire logic enable,
   output logic     pulse
);
   int cnt;
   // The wave only feeds the counter, never the system clock.
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst || !enable)
      begin
         cnt <= 0;
         pulse <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         pulse <= !pulse;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`include "tbc_map.svh"
module tb_top;
   import tbc_pkg::*;
   typedef struct {logic [7:0] ctl; int dv;} tbc_row_type;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [`TBC_ADDR_W-1:0] avsAddress = '0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = '0;
   logic [31:0] avsReaddata;
   logic avsWaitrequest, u1, u2, irq, pulse;
   logic [3:0] ccMode2 = 4'h0;
   logic ccMatch2 = 1'b0;
   logic pulseEn = 1'b0;
   logic [1:0] portPinIn = 2'b00;
   logic [1:0] pinRead, pinForce;
   logic [7:0] q;
   logic [15:0] c;
   int fails = 0;
   int samplesChecked = 0;
   tbc_row_type rows [8] = '{'{8'h01, 1}, '{8'h15, 2}, '{8'h21, 4},
      '{8'h35, 8}, '{8'h03, 1}, '{8'h07, 1}, '{8'h13, 2}, '{8'h27, 4}};
   logic [7:0] sel [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
   always #2 clk_sys = ~clk_sys;
   tbc_pulse_src src (.clk_sys(clk_sys), .rst(rst), .enable(pulseEn),
      .pulse(pulse));
   tbc_timer DUT (.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsByteenable(4'hF), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .externalCountPin(pulse),
      .secOscInPin(pulse), .ccMode1(4'h0), .ccMode2(ccMode2),
      .ccMatch1(1'b0), .ccMatch2(ccMatch2), .ccUnit1UsesThis(u1),
      .ccUnit2UsesThis(u2), .portPinIn(portPinIn), .portReadValue(pinRead),
      .portPinForceInput(pinForce), .irq(irq));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      samplesChecked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkIn(string n, int lo, int hi, logic [15:0] g);
      samplesChecked++;
      if ((^g === 1'bx) || g < lo || g > hi)
      begin
         fails++;
         $display("[FAIL] %s expected %0d..%0d seen %h", n, lo, hi, g);
      end
   endtask
   // Holds the request until waitrequest is sampled low at an edge.
   task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
      int i;
      avsAddress <= {a, 2'b00};
      avsWrite <= w;
      avsRead <= !w;
      avsWritedata <= {24'h0, d};
      i = 0;
      do
      begin
         @(posedge clk_sys);
         i++;
      end
      while (avsWaitrequest !== 1'b0 && i < 20);
      if (avsWaitrequest !== 1'b0)
      begin
         fails++;
         end_of_test();
      end
      q = avsReaddata[7:0];
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rdCnt();
      bus(0, 1, 0);
      c[7:0] = q;
      bus(0, 2, 0);
      c[15:8] = q;
   endtask
   task automatic trig();
      ccMatch2 <= 1'b1;
      @(posedge clk_sys);
      ccMatch2 <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      foreach (rows[k])
      begin
         bus(1, 0, 8'h00);
         bus(1, 2, 8'h00);
         bus(1, 1, 8'h00);
         pulseEn <= rows[k].ctl[1];
         bus(1, 0, rows[k].ctl);
         repeat (32 * rows[k].dv) @(posedge clk_sys);
         bus(1, 0, 8'h00);
         pulseEn <= 1'b0;
         rdCnt();
         chkIn("count", 6, 9, c);
         $display("row %0d done", k);
      end
      bus(1, 2, 8'hFF);
      bus(1, 1, 8'hFC);
      bus(1, 4, 8'h01);
      bus(1, 0, 8'h01);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_sys);
      chk("irq", 1, irq);
      bus(1, 0, 8'h00);
      rdCnt();
      chkIn("wrap", 0, 4, c);
      bus(1, 4, 8'h00);
      chk("masked irq", 0, irq);
      bus(0, 3, 0);
      chk("status", 1, q);
      bus(0, 3, 0);
      chk("status clear", 0, q);
      bus(1, 4, 8'h01);
      chk("irq clear", 0, irq);
      $display("overflow done");
      bus(1, 0, 8'h80);
      bus(1, 2, 8'h12);
      bus(1, 1, 8'h34);
      bus(1, 2, 8'h56);
      bus(0, 1, 0);
      bus(0, 2, 0);
      chk("wide high", 8'h12, q);
      bus(1, 0, 8'h00);
      rdCnt();
      chk("wide count", 16'h1234, c);
      $display("wide done");
      ccMode2 <= `TBC_CC_TRIG_MODE;
      trig();
      rdCnt();
      chk("other base", 16'h1234, c);
      bus(1, 0, 8'h08);
      trig();
      rdCnt();
      chk("trigger", 0, c);
      bus(0, 3, 0);
      chk("trig status", 8'h02, q);
      foreach (sel[k])
      begin
         bus(1, 0, sel[k]);
         chk("time base", {sel[k][6], sel[k][6] | sel[k][3]}, {u1, u2});
      end
      $display("trigger done");
      portPinIn <= 2'b11;
      bus(1, 5, 8'h01);
      chk("pin force", 3, pinForce);
      chk("pin read", 0, pinRead);
      bus(1, 5, 8'h00);
      chk("pin pass", 3, pinRead);
      bus(1, 4'hE, 8'hAA);
      bus(0, 4'hE, 0);
      chk("unmapped", 0, q);
      $display("pins done");
      rst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      bus(0, 0, 0);
      chk("control reset", 0, q);
      bus(0, 4, 0);
      chk("mask reset", 0, q);
      rdCnt();
      chk("count reset", 0, c);
      $display("reset done");
      end_of_test();
   end
endmodule
